/* host_status_reset_msg_handler.v */
// host message interpreter for reset, self-check, status queries and output pins
`timescale 1ns/10ps
`include "msg_handler_map.vh"

module host_status_reset_msg_handler
#(
   parameter        REDUCED        = 0,
   parameter        FREG_AW        = 4,
   parameter [31:0] SELF_CHECK_CYC = `SELF_CHECK_CYC
)
(
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // message bytes from the serial link
   input  wire        rx_valid_i,
   input  wire [7:0]  rx_data_i,
   output wire        rx_ready_o,
   output reg         tx_valid_o,
   output reg  [7:0]  tx_data_o,
   input  wire        tx_ready_i,
   // device state from the rest of the chip
   input  wire [15:0] err_a_set_i,
   input  wire [15:0] err_b_set_i,
   input  wire [15:0] channel_a_state_i,
   input  wire [15:0] channel_b_state_i,
   input  wire [7:0]  volume_a_i,
   input  wire [7:0]  volume_b_i,
   input  wire [7:0]  speed_a_i,
   input  wire [7:0]  pitch_a_i,
   input  wire [15:0] tone_freq_i,
   input  wire        tone_on_i,
   input  wire [31:0] rom_addr_i,
   input  wire [31:0] rom_size_i,
   input  wire        rom_external_i,
   // sound drive from the playback path
   input  wire        spk_drv_p_i,
   input  wire        spk_drv_n_i,
   input  wire        bz_drv_p_i,
   input  wire        bz_drv_n_i,
   input  wire        bz2_drv_p_i,
   input  wire        bz2_drv_n_i,
   // status and control outputs
   output wire        error_o,
   output wire        status_o,
   output reg         forced_reset_o,
   output wire        sample_8k_o,
   // output pins, enable low while driving
   output reg         spk_p_o,
   output reg         spk_p_oe_n_o,
   output reg         spk_n_o,
   output reg         spk_n_oe_n_o,
   output reg         bz_p_o,
   output reg         bz_p_oe_n_o,
   output reg         bz_n_o,
   output reg         bz_n_oe_n_o,
   output reg         bz_secondary_pos_o,
   output reg         bz_secondary_pos_oe_n_o,
   output reg         bz_secondary_neg_o,
   output reg         bz_secondary_neg_oe_n_o,
   output reg         amp_enable_out_o
);

   localparam [4:0] S_ID    = 5'b00001;
   localparam [4:0] S_ARG   = 5'b00010;
   localparam [4:0] S_CRC   = 5'b00100;
   localparam [4:0] S_TX    = 5'b01000;
   localparam [4:0] S_CHECK = 5'b10000;
   localparam       FREG_N  = 1 << FREG_AW;

   // ****************************************
   // crc over request bytes
   // ****************************************
   function [7:0] crc8_step;
      input [7:0] crc;
      input [7:0] data;
      reg   [7:0] c;
      integer     i;
      begin
         c = crc ^ data;
         for (i = 0; i < 8; i = i + 1)
            c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
         crc8_step = c;
      end
   endfunction

   reg  [4:0]  state_reg;
   reg  [7:0]  id_reg;
   reg  [7:0]  arg0_reg;
   reg  [7:0]  arg1_reg;
   reg  [1:0]  cnt_reg;
   reg  [1:0]  need_reg;
   reg  [7:0]  crc_reg;
   reg  [8:0]  tx_len_reg;
   reg  [8:0]  tx_idx_reg;
   reg  [7:0]  ind_type_reg;
   reg  [7:0]  ind_count_reg;
   reg         selfchk_pend_reg;
   reg         forced_pend_reg;
   reg  [31:0] check_cnt_reg;
   reg         soft_rst_reg;
   reg  [7:0]  out_sel_reg;
   reg         rate_8k_reg;
   reg         amp_on_reg;
   reg  [15:0] err_a_reg;
   reg  [15:0] err_b_reg;
   reg         crc_en_reg;
   reg  [23:0] flash_id_reg;
   reg  [7:0]  freg_mem [0:FREG_N-1];

   // forced reset restarts this block like the hardware reset does
   wire rst_all = rst_i | soft_rst_reg;
   wire rx_take = rx_valid_i & (state_reg == S_ID || state_reg == S_ARG || state_reg == S_CRC);
   wire crc_ok  = (crc_reg == rx_data_i);
   wire exec    = rx_take & (state_reg == S_CRC) & crc_ok;
   wire clr_nf  = exec & (id_reg == `ID_RESET) & ~arg0_reg[0];

   assign rx_ready_o  = (state_reg == S_ID) | (state_reg == S_ARG) | (state_reg == S_CRC);
   assign status_o    = (state_reg == S_CHECK);
   assign error_o     = |{err_a_reg, err_b_reg};
   assign sample_8k_o = rate_8k_reg;

   // ****************************************
   // response byte selection
   // ****************************************
   wire [8:0]  nidx = tx_idx_reg + 9'h001;
   wire [7:0]  pidx = tx_idx_reg[7:0];    // payload byte of response index nidx
   wire [7:0]  pitch_rep = (REDUCED != 0) ? 8'h00 : pitch_a_i;
   reg  [79:0] payload;
   reg  [7:0]  next_byte;

   // payload packed low byte first, byte k goes out as response byte k+1
   always @*
   begin
      payload = 80'h0;
      case (ind_type_reg)
         `IND_ERROR:       payload[31:0] = {err_b_reg, err_a_reg};
         `IND_CHAN_STATE:  payload[31:0] = {channel_b_state_i, channel_a_state_i};
         `IND_CRC_SETTING: payload[7:0]  = {7'h00, crc_en_reg};
         `IND_EFFECTS:     payload[63:0] = {out_sel_reg, 7'h00, tone_on_i, tone_freq_i,
                                            pitch_rep, speed_a_i, volume_b_i,
                                            volume_a_i};
         `IND_ROM:         payload[71:0] = {7'h00, rom_external_i, rom_size_i, rom_addr_i};
         `IND_FLASH_ID:    payload[23:0] = flash_id_reg;
         `IND_OUT_STATE:   payload[47:0] = {7'h00, status_o, 7'h00, tone_on_i,
                                            channel_b_state_i, channel_a_state_i};
         default:          payload = 80'h0;
      endcase
      if (ind_type_reg == `IND_FLASH_REG)
         next_byte = freg_mem[pidx[FREG_AW-1:0]];
      else
         next_byte = payload[{pidx[3:0], 3'b000} +: 8];
   end

   // ****************************************
   // message state machine
   // ****************************************
   // an unknown identifier gets one bad-id status; its trailing bytes are then
   // taken as fresh identifiers, since the length of a foreign message is unknown
   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         state_reg        <= S_ID;
         id_reg           <= 8'h00;
         arg0_reg         <= 8'h00;
         arg1_reg         <= 8'h00;
         cnt_reg          <= 2'd0;
         need_reg         <= 2'd0;
         crc_reg          <= `CRC_INIT;
         tx_len_reg       <= `LEN_ONE;
         tx_idx_reg       <= 9'h000;
         ind_type_reg     <= 8'hFF;
         ind_count_reg    <= 8'h00;
         selfchk_pend_reg <= 1'b0;
         forced_pend_reg  <= 1'b0;
         check_cnt_reg    <= 32'h0;
         soft_rst_reg     <= 1'b0;
         out_sel_reg      <= `SEL_SPEAKER;
         rate_8k_reg      <= 1'b0;
         amp_on_reg       <= 1'b0;
         tx_valid_o       <= 1'b0;
         tx_data_o        <= 8'h00;
         forced_reset_o   <= 1'b0;
      end
      else
      begin
         forced_reset_o <= 1'b0;
         if (rx_take)
            crc_reg <= crc8_step(crc_reg, rx_data_i);
         case (state_reg)
            S_ID:
               if (rx_valid_i)
               begin
                  id_reg        <= rx_data_i;
                  cnt_reg       <= 2'd0;
                  ind_type_reg  <= 8'hFF;
                  ind_count_reg <= 8'h00;
                  if (rx_data_i == `ID_SELF_CHECK)
                     state_reg <= S_CRC;
                  else if (rx_data_i == `ID_RESET || rx_data_i == `ID_AMP_CONTROL ||
                           rx_data_i == `ID_STATUS)
                  begin
                     need_reg  <= 2'd1;
                     state_reg <= S_ARG;
                  end
                  else if (rx_data_i == `ID_OUT_CONFIG)
                  begin
                     need_reg  <= 2'd2;
                     state_reg <= S_ARG;
                  end
                  else
                  begin
                     tx_data_o  <= `RS_BAD_ID;
                     crc_reg    <= `CRC_INIT;    // next message starts a fresh check
                     tx_len_reg <= `LEN_ONE;
                     tx_idx_reg <= 9'h000;
                     tx_valid_o <= 1'b1;
                     state_reg  <= S_TX;
                  end
               end
            S_ARG:
               if (rx_valid_i)
               begin
                  if (cnt_reg == 2'd0)
                     arg0_reg <= rx_data_i;
                  else
                     arg1_reg <= rx_data_i;
                  cnt_reg <= cnt_reg + 2'd1;
                  // flash register readback carries a count before the check byte
                  if (id_reg == `ID_STATUS && cnt_reg == 2'd0 &&
                      rx_data_i == `IND_FLASH_REG)
                     need_reg <= 2'd2;
                  else if (cnt_reg + 2'd1 == need_reg)
                     state_reg <= S_CRC;
               end
            S_CRC:
               if (rx_valid_i)
               begin
                  crc_reg    <= `CRC_INIT;
                  tx_idx_reg <= 9'h000;
                  tx_len_reg <= `LEN_ONE;
                  tx_valid_o <= 1'b1;
                  state_reg  <= S_TX;
                  tx_data_o  <= `RS_OK;
                  if (!crc_ok)
                     tx_data_o <= `RS_CRC_ERR;
                  else if (id_reg == `ID_RESET)
                     forced_pend_reg <= arg0_reg[0];
                  else if (id_reg == `ID_SELF_CHECK)
                     selfchk_pend_reg <= 1'b1;
                  else if (id_reg == `ID_AMP_CONTROL)
                     amp_on_reg <= arg0_reg[0];
                  else if (id_reg == `ID_OUT_CONFIG)
                  begin
                     if (arg0_reg == `SEL_SPEAKER || arg0_reg == `SEL_BUZ2_SPK ||
                         (REDUCED == 0 && (arg0_reg == `SEL_BUZ2 ||
                                           arg0_reg == `SEL_BUZ4)))
                     begin
                        out_sel_reg <= arg0_reg;
                        rate_8k_reg <= arg1_reg[0];
                     end
                     else
                        tx_data_o <= `RS_BAD_PARAM;
                  end
                  else
                  begin
                     ind_type_reg  <= arg0_reg;
                     ind_count_reg <= arg1_reg;
                     case (arg0_reg)
                        `IND_ERROR:       tx_len_reg <= `LEN_ERROR;
                        `IND_CHAN_STATE:  tx_len_reg <= `LEN_CHAN_STATE;
                        `IND_CRC_SETTING: tx_len_reg <= `LEN_CRC_SETTING;
                        `IND_EFFECTS:     tx_len_reg <= `LEN_EFFECTS;
                        `IND_ROM:         tx_len_reg <= `LEN_ROM;
                        `IND_FLASH_ID:    tx_len_reg <= `LEN_FLASH_ID;
                        `IND_FLASH_REG:   tx_len_reg <= {1'b0, arg1_reg} + `LEN_ONE;
                        `IND_OUT_STATE:   tx_len_reg <= `LEN_OUT_STATE;
                        default:          tx_data_o  <= `RS_BAD_PARAM;
                     endcase
                  end
               end
            S_TX:
               if (tx_ready_i)
               begin
                  if (nidx == tx_len_reg)
                  begin
                     tx_valid_o <= 1'b0;
                     if (selfchk_pend_reg)
                     begin
                        selfchk_pend_reg <= 1'b0;
                        check_cnt_reg    <= SELF_CHECK_CYC;
                        state_reg        <= S_CHECK;
                     end
                     else
                     begin
                        // restart only once the status byte has left
                        soft_rst_reg   <= forced_pend_reg;
                        forced_reset_o <= forced_pend_reg;
                        state_reg      <= S_ID;
                     end
                  end
                  else
                  begin
                     tx_idx_reg <= nidx;
                     tx_data_o  <= next_byte;
                  end
               end
            S_CHECK:
               if (check_cnt_reg <= 32'h1)
               begin
                  ind_type_reg <= 8'hFF;
                  tx_len_reg   <= `LEN_ONE;
                  tx_idx_reg   <= 9'h000;
                  tx_data_o    <= `RS_OK;
                  tx_valid_o   <= 1'b1;
                  state_reg    <= S_TX;
               end
               else
                  check_cnt_reg <= check_cnt_reg - 32'h1;
            default:
               state_reg <= S_ID;
         endcase
      end
   end

   // ****************************************
   // error words
   // ****************************************
   // a new error in the clearing cycle survives the clear
   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         err_a_reg <= 16'h0000;
         err_b_reg <= 16'h0000;
      end
      else
      begin
         err_a_reg <= ((clr_nf ? {err_a_reg[15:8], 8'h00} : err_a_reg) | err_a_set_i);
         err_b_reg <= ((clr_nf ? {err_b_reg[15:8], 8'h00} : err_b_reg) | err_b_set_i);
      end
   end

   // ****************************************
   // output pin states
   // ****************************************
   // pins follow selection and amplifier control, registered for clean edges
   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         spk_p_o                 <= 1'b0;
         spk_p_oe_n_o            <= 1'b0;
         spk_n_o                 <= 1'b0;
         spk_n_oe_n_o            <= 1'b0;
         bz_p_o                  <= 1'b0;
         bz_p_oe_n_o             <= 1'b1;
         bz_n_o                  <= 1'b0;
         bz_n_oe_n_o             <= 1'b1;
         bz_secondary_pos_o      <= 1'b0;
         bz_secondary_pos_oe_n_o <= 1'b1;
         bz_secondary_neg_o      <= 1'b0;
         bz_secondary_neg_oe_n_o <= 1'b1;
         amp_enable_out_o        <= 1'b0;
      end
      else
      begin
         // speaker pair used by speaker and two-pin-with-speaker selections
         spk_p_oe_n_o <= (out_sel_reg == `SEL_BUZ2 || out_sel_reg == `SEL_BUZ4);
         spk_n_oe_n_o <= (out_sel_reg == `SEL_BUZ2 || out_sel_reg == `SEL_BUZ4);
         spk_p_o      <= amp_on_reg & spk_drv_p_i;
         spk_n_o      <= amp_on_reg & spk_drv_n_i;
         // primary buzzer pair only in the two-pin and four-pin selections, not two-pin-with-speaker
         bz_p_oe_n_o  <= ~(out_sel_reg == `SEL_BUZ2 || out_sel_reg == `SEL_BUZ4);
         bz_n_oe_n_o  <= ~(out_sel_reg == `SEL_BUZ2 || out_sel_reg == `SEL_BUZ4);
         bz_p_o       <= amp_on_reg & bz_drv_p_i;
         bz_n_o       <= amp_on_reg & bz_drv_n_i;
         // secondary pair rests high when off, four-pin selection only
         bz_secondary_pos_oe_n_o <= (out_sel_reg != `SEL_BUZ4);
         bz_secondary_neg_oe_n_o <= (out_sel_reg != `SEL_BUZ4);
         bz_secondary_pos_o      <= amp_on_reg ? bz2_drv_p_i : 1'b1;
         bz_secondary_neg_o      <= amp_on_reg ? bz2_drv_n_i : 1'b1;
         // two-pin selections invert the amplifier control level
         if (out_sel_reg == `SEL_BUZ2 || out_sel_reg == `SEL_BUZ2_SPK)
            amp_enable_out_o <= ~amp_on_reg;
         else
            amp_enable_out_o <= amp_on_reg;
      end
   end

   // ****************************************
   // wishbone slave
   // ****************************************
   // one wait state; write lands on the edge the master sees ack
   wire wb_req = wb_cyc_i & wb_stb_i;
   wire wb_wr  = wb_req & wb_we_i & wb_ack_o;
   wire wb_win = ((wb_adr_i & `FREG_WIN_MASK) == `REG_FREG_BASE);

   always @(posedge clk_i)
   begin
      if (rst_all)
      begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h0;
         crc_en_reg   <= 1'b0;
         flash_id_reg <= 24'h0;
      end
      else
      begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         if (wb_req & ~wb_ack_o)
         begin
            if (wb_adr_i == `REG_CTRL)
               wb_dat_o <= {31'h0, crc_en_reg};
            else if (wb_adr_i == `REG_FLASH_ID)
               wb_dat_o <= {8'h00, flash_id_reg};
            else if (wb_adr_i == `REG_ERR_A)
               wb_dat_o <= {16'h0, err_a_reg};
            else if (wb_adr_i == `REG_ERR_B)
               wb_dat_o <= {16'h0, err_b_reg};
            else if (wb_adr_i == `REG_PIN_STATE)
               wb_dat_o <= {21'h0, status_o, rate_8k_reg, amp_on_reg, out_sel_reg};
            else if (wb_win)
               wb_dat_o <= {24'h0, freg_mem[wb_adr_i[FREG_AW+1:2]]};
            else
               wb_dat_o <= 32'h0;
         end
         if (wb_wr && wb_adr_i == `REG_CTRL && wb_sel_i[0])
            crc_en_reg <= wb_dat_i[`CTRL_CRC_EN];
         if (wb_wr && wb_adr_i == `REG_FLASH_ID)
         begin
            if (wb_sel_i[0])
               flash_id_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               flash_id_reg[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2])
               flash_id_reg[23:16] <= wb_dat_i[23:16];
         end
      end
   end

   // flash register bytes left by the last register read operation
   always @(posedge clk_i)
   begin
      if (wb_wr && wb_win && wb_sel_i[0])
         freg_mem[wb_adr_i[FREG_AW+1:2]] <= wb_dat_i[7:0];
   end

endmodule

/* msg_handler_map.vh */
// constants for the host status / reset message handler
`ifndef MSG_HANDLER_MAP_VH
`define MSG_HANDLER_MAP_VH

// message identifiers
`define ID_RESET         8'h99
`define ID_SELF_CHECK    8'hF0
`define ID_STATUS        8'h0D
`define ID_OUT_CONFIG    8'h0E
`define ID_AMP_CONTROL   8'h16

// status query indication types
`define IND_ERROR        8'h00
`define IND_CHAN_STATE   8'h01
`define IND_CRC_SETTING  8'h02
`define IND_EFFECTS      8'h03
`define IND_ROM          8'h04
`define IND_FLASH_ID     8'h06
`define IND_FLASH_REG    8'h07
`define IND_OUT_STATE    8'h08

// response lengths in bytes, receive-status byte included
`define LEN_ONE          9'h001
`define LEN_ERROR        9'h005
`define LEN_CHAN_STATE   9'h005
`define LEN_CRC_SETTING  9'h002
`define LEN_EFFECTS      9'h009
`define LEN_ROM          9'h00A
`define LEN_FLASH_ID     9'h004
`define LEN_OUT_STATE    9'h007

// receive-status codes
`define RS_OK            8'h00
`define RS_CRC_ERR       8'h01
`define RS_BAD_ID        8'h02
`define RS_BAD_PARAM     8'h03

// output selections
`define SEL_SPEAKER      8'h00
`define SEL_BUZ2         8'h05
`define SEL_BUZ4         8'h06
`define SEL_BUZ2_SPK     8'h07

// request check byte: crc-8, polynomial and initial value
`define CRC_POLY         8'h07
`define CRC_INIT         8'h00

// self-check duration
`define SELF_CHECK_NS    10000
`define CLK_PERIOD_NS    8
`define SELF_CHECK_CYC   (`SELF_CHECK_NS / `CLK_PERIOD_NS)

// wishbone register byte offsets
`define REG_CTRL         8'h00
`define REG_FLASH_ID     8'h04
`define REG_ERR_A        8'h08
`define REG_ERR_B        8'h0C
`define REG_PIN_STATE    8'h10
`define REG_FREG_BASE    8'h40
`define FREG_WIN_MASK    8'hC0

// field positions
`define CTRL_CRC_EN      0
`define PST_AMP          8
`define PST_RATE         9
`define PST_BUSY         10

`endif

/* hsr_port_checker_assertions.sv */
// concurrent checks on the host message handler ports
`timescale 1ns/10ps
module hsr_port_checker #(parameter [31:0] SELF_CHECK_CYC = 32'h4E2) (
   input wire        clk_i, rst_i, status_o, error_o, forced_reset_o,
   input wire        tx_valid_o, tx_ready_i, rx_ready_o, amp_enable_out_o,
   input wire        spk_p_oe_n_o, bz_p_oe_n_o, bz_secondary_pos_oe_n_o,
   input wire [7:0]  tx_data_o,
   input wire [15:0] err_a_set_i
);
   reg [31:0] busy_cnt;
   // length of the current busy stretch, so the check needs no long repetition
   always @(posedge clk_i)
      busy_cnt <= (rst_i || !status_o) ? 32'h0 : busy_cnt + 32'h1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_busy_length: assert property ($fell(status_o) |-> busy_cnt == SELF_CHECK_CYC)
      else $error("busy length wrong");
   chk_done_byte: assert property ($fell(status_o) |-> ##[0:3] (tx_valid_o && !tx_data_o))
      else $error("no completion byte");
   chk_restart_state: assert property (forced_reset_o |=> !amp_enable_out_o && !error_o)
      else $error("state kept over restart");
   chk_error_flag: assert property (|err_a_set_i |=> error_o)
      else $error("error flag missing");
   chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("reply byte dropped");
   chk_rx_refuse: assert property (tx_valid_o |-> !rx_ready_o)
      else $error("request taken while replying");
   chk_spk_alone: assert property (!spk_p_oe_n_o |-> bz_p_oe_n_o && bz_secondary_pos_oe_n_o)
      else $error("buzzer driven with speaker");
   chk_four_pin: assert property (!bz_secondary_pos_oe_n_o |-> !bz_p_oe_n_o && spk_p_oe_n_o)
      else $error("four-pin mode pins wrong");
endmodule
bind host_status_reset_msg_handler hsr_port_checker #(.SELF_CHECK_CYC(SELF_CHECK_CYC))
   hsr_port_checker_i (.*);

/* host_link_model.sv */
// host side model: sends request bytes with a check byte, takes replies
`timescale 1ns/10ps
module host_link_model (
   input  wire       clk_i,
   input  wire       ready_i,
   output reg        valid_o = 1'b0,
   output reg  [7:0] data_o  = 8'h00,
   output reg        take_o  = 1'b0
);
   reg [7:0] crc_reg   = 8'h00;
   reg [3:0] stall_reg = 4'h9;
   // uneven take pattern, so replies meet prompt and slow hosts
   always @(posedge clk_i)
   begin
      stall_reg <= {stall_reg[2:0], stall_reg[3] ^ stall_reg[2]};
      take_o    <= stall_reg[0] | stall_reg[1];
   end
   // one request byte, held until the device takes it
   task put_byte(input [7:0] b);
      integer k;
      begin
         @(posedge clk_i);
         valid_o <= 1'b1;
         data_o  <= b;
         crc_reg = crc_reg ^ b;
         for (k = 0; k < 8; k++)
            crc_reg = {crc_reg[6:0], 1'b0} ^ (crc_reg[7] ? 8'h07 : 8'h00);
         k = 0;
         @(posedge clk_i);
         while (ready_i !== 1'b1 && k++ < 4000)
            @(posedge clk_i);
         valid_o <= 1'b0;
         data_o  <= ~b; // idle line never repeats the last byte
      end
   endtask
   // trailing check byte; a set flag spoils it on purpose
   task end_msg(input bad);
      begin
         put_byte(crc_reg ^ {7'h00, bad});
         crc_reg = 8'h00;
      end
   endtask
endmodule

/* testbench.sv */
// self-checking bench for the host message handler
`timescale 1ns/10ps
module testbench;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, tone_on_i = '0;
   logic rom_external_i = '0, drv = '0, rate;
   logic [3:0] wb_sel_i = 4'hF;
   logic [5:0] oes [4] = '{6'h0F, 6'h33, 6'h30, 6'h0F};
   logic [7:0] wb_adr_i = '0, volume_a_i = '0, volume_b_i = '0, speed_a_i = '0, pitch_a_i = '0;
   logic [7:0] sels [4] = '{8'h00, 8'h05, 8'h06, 8'h07}, lf = 8'h27, exp_q [$];
   logic [15:0] err_a_set_i = '0, err_b_set_i = '0, channel_a_state_i = '0, tone_freq_i = '0;
   logic [15:0] channel_b_state_i = '0;
   logic [31:0] wb_dat_i = '0, rom_addr_i = '0, rom_size_i = '0, q;
   wire spk_drv_p_i = drv, spk_drv_n_i = drv, bz_drv_p_i = drv, bz_drv_n_i = drv;
   wire bz2_drv_p_i = !drv, bz2_drv_n_i = !drv;
   wire [31:0] wb_dat_o;
   wire [7:0] tx_data_o, rx_data_i;
   wire wb_ack_o, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, error_o, status_o;
   wire forced_reset_o, sample_8k_o, spk_p_o, spk_p_oe_n_o, spk_n_o, spk_n_oe_n_o, bz_p_o;
   wire bz_p_oe_n_o, bz_n_o, bz_n_oe_n_o, bz_secondary_pos_o, bz_secondary_pos_oe_n_o;
   wire bz_secondary_neg_o, bz_secondary_neg_oe_n_o, amp_enable_out_o;
   wire [5:0] oe_w = {spk_p_oe_n_o, spk_n_oe_n_o, bz_p_oe_n_o, bz_n_oe_n_o,
                      bz_secondary_pos_oe_n_o, bz_secondary_neg_oe_n_o};
   wire [5:0] pin_w = {spk_p_o, spk_n_o, bz_p_o, bz_n_o, bz_secondary_pos_o, bz_secondary_neg_o};
   integer n_mismatch = 0, n_checks = 0, k;
   host_status_reset_msg_handler #(.SELF_CHECK_CYC(32'h4)) host_status_reset_msg_handler_i (.*);
   host_link_model host_link_model_i (.clk_i(clk_i), .ready_i(rx_ready_o), .valid_o(rx_valid_i),
      .data_o(rx_data_i), .take_o(tx_ready_i));
   // 125 MHz
   always #4 clk_i = !clk_i;
   function [7:0] rnd;
      begin
         lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
         rnd = lf;
      end
   endfunction
   task chk(input [31:0] got, input [31:0] want);
      begin
         n_checks++;
         if (got !== want)
         begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, want);
         end
      end
   endtask
   task report_and_stop(input bad);
      begin
         n_mismatch = n_mismatch + bad;
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task wb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i  <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         k = 0;
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1 && k++ < 50)
            @(posedge clk_i);
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         if (k >= 50)
            report_and_stop(1);
      end
   endtask
   // two bytes and the check byte
   task msg(input [7:0] a, input [7:0] b, input bad);
      begin
         host_link_model_i.put_byte(a);
         host_link_model_i.put_byte(b);
         host_link_model_i.end_msg(bad);
      end
   endtask
   task drain;
      begin
         k = 0;
         while (exp_q.size() != 0 && k++ < 4000)
            @(posedge clk_i);
         if (k >= 4000)
            report_and_stop(1);
         repeat (3) @(posedge clk_i);
      end
   endtask
   // every reply byte taken is held against the oldest note
   always @(posedge clk_i)
      if ((tx_valid_o & tx_ready_i) === 1'b1)
         chk(tx_data_o, exp_q.size() ? exp_q.pop_front() : 32'h100);
   // main sequence
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1, 8'h00, 32'h1);
      wb(0, 8'h24, 32'h0);
      chk(q, 32'h0);
      exp_q = {8'h00, 8'h01, 8'h01};
      msg(8'h0D, 8'h02, 0);
      msg(8'h0D, 8'h02, 1);
      drain;
      err_a_set_i <= 16'h0181;
      err_b_set_i <= 16'h0200;
      @(posedge clk_i);
      err_a_set_i <= '0;
      err_b_set_i <= '0;
      @(posedge clk_i);
      chk(error_o, 1'b1);
      exp_q = {8'h00, 8'h81, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02};
      msg(8'h0D, 8'h00, 0);
      msg(8'h99, 8'h00, 0);
      msg(8'h0D, 8'h00, 0);
      channel_a_state_i <= 16'h0002;
      channel_b_state_i <= 16'h0004;
      exp_q = {exp_q, 8'h00, 8'h02, 8'h00, 8'h04, 8'h00};
      exp_q = {exp_q, 8'h00, 8'h02, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
      msg(8'h0D, 8'h01, 0);
      msg(8'h0D, 8'h08, 0);
      drain;
      volume_a_i <= rnd();
      volume_b_i <= rnd();
      speed_a_i <= rnd();
      pitch_a_i <= rnd();
      tone_freq_i <= {rnd(), rnd()};
      tone_on_i <= 1'b1;
      rom_addr_i <= {rnd(), rnd(), rnd(), rnd()};
      rom_size_i <= {rnd(), rnd(), rnd(), rnd()};
      rom_external_i <= 1'b1;
      wb(1, 8'h40, 32'h3C);
      wb(1, 8'h04, 32'h00C3A55A);
      exp_q = {8'h00, volume_a_i, volume_b_i, speed_a_i, pitch_a_i, tone_freq_i[7:0]};
      exp_q = {exp_q, tone_freq_i[15:8], 8'h01, 8'h00, 8'h00, 8'h5A, 8'hA5, 8'hC3, 8'h00, 8'h00};
      exp_q = {exp_q, 8'h00, 8'h3C, 8'h00};
      for (int j = 0; j < 4; j++)
         exp_q = {exp_q, rom_addr_i[8 * j +: 8]};
      for (int j = 0; j < 4; j++)
         exp_q = {exp_q, rom_size_i[8 * j +: 8]};
      exp_q = {exp_q, 8'h01};
      msg(8'h0D, 8'h03, 0);
      msg(8'h0D, 8'h06, 0);
      host_link_model_i.put_byte(8'hF0);
      host_link_model_i.end_msg(0);
      host_link_model_i.put_byte(8'h0D);
      msg(8'h07, 8'h01, 0);
      msg(8'h0D, 8'h04, 0);
      drain;
      for (int i = 0; i < 8; i++)
      begin
         drv <= rnd() > 8'h7F;
         rate = lf[5];
         exp_q = {8'h00, 8'h00};
         host_link_model_i.put_byte(8'h0E);
         msg(sels[i / 2], {7'h00, rate}, 0);
         msg(8'h16, {7'h00, i[0]}, 0);
         drain;
         chk(oe_w, oes[i / 2]);
         chk(pin_w & ~oes[i / 2], (i % 2 ? {{4{drv}}, {2{!drv}}} : 6'h03) & ~oes[i / 2]);
         chk({amp_enable_out_o, sample_8k_o}, {i[0] ^ i[1], rate});
      end
      exp_q = {8'h00};
      msg(8'h99, 8'h01, 0);
      drain;
      wb(0, 8'h10, 32'h0);
      chk(q, 32'h0);
      report_and_stop(0);
   end
endmodule
